/* bsce_pkg.sv */
// Constants, opcodes and carriers of the branch/skip/compare executor.
// Assumes a 22-bit word program counter and an 8-bit status flag register.
package bsce_pkg;

  // ==========================================================================
  // Widths
  localparam int PC_W  = 22;
  localparam int DAT_W = 8;

  // ==========================================================================
  // Status flag bit positions
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_S = 3'h4;
  localparam logic [2:0] FLG_H = 3'h5;
  localparam logic [2:0] FLG_T = 3'h6;
  localparam logic [2:0] FLG_I = 3'h7;

  // ==========================================================================
  // Cycle counts
  localparam logic [2:0] CYC_EXTENDED_INDIRECT_CALL     = 3'h3;
  localparam logic [2:0] CYC_CALL_SHORT = 3'h3;
  localparam logic [2:0] CYC_CALL_LONG  = 3'h4;
  localparam logic [2:0] CYC_RET_SHORT  = 3'h4;
  localparam logic [2:0] CYC_RET_LONG   = 3'h5;
  localparam logic [2:0] CYC_ONE        = 3'h1;
  localparam logic [2:0] CYC_TWO        = 3'h2;
  localparam logic [2:0] CYC_LDS        = 3'h2;
  localparam logic [2:0] CYC_IO_EXTRA   = 3'h1;

  // ==========================================================================
  // Reset values
  localparam logic [PC_W-1:0]  PC_RST   = 22'h000000;
  localparam logic [DAT_W-1:0] STATUS_FLAG_REGISTER_RST = 8'h00;

  // ==========================================================================
  // Operations
  typedef enum logic [4:0] {
    OP_NONE         = 5'h00,
    OP_EXTENDED_INDIRECT_CALL       = 5'h01,
    OP_CALL         = 5'h02,
    OP_RET          = 5'h03,
    OP_INTERRUPT_EXIT         = 5'h04,
    OP_SKIP_EQ      = 5'h05,
    OP_CMP          = 5'h06,
    OP_CMP_BORROW   = 5'h07,
    OP_CMP_IMM      = 5'h08,
    OP_SKIP_RB_CLR  = 5'h09,
    OP_SKIP_RB_SET  = 5'h0A,
    OP_SKIP_IO_CLR  = 5'h0B,
    OP_SKIP_IO_SET  = 5'h0C,
    OP_BR_FLAG_SET  = 5'h0D,
    OP_BR_FLAG_CLR  = 5'h0E,
    OP_BR_SIGNED_GE = 5'h0F,
    OP_BR_SIGNED_LT = 5'h10,
    OP_MOVE         = 5'h11,
    OP_MOVE_PAIR    = 5'h12,
    OP_LOAD_IMM     = 5'h13,
    OP_DIRECT_LOAD  = 5'h14
  } bsce_op_t;

  // Decoded instruction
  typedef struct packed {
    bsce_op_t         op;
    logic [2:0]       bit_sel;
    logic [11:0]      offset;
    logic [PC_W-1:0]  target;
    logic [DAT_W-1:0] opd_a;
    logic [DAT_W-1:0] opd_b;
    logic [DAT_W-1:0] io_val;
    logic [15:0]      z_ptr;
    logic             next_two_word;
    logic             pc22;
  } bsce_instr_t;

  // Execution result
  typedef struct packed {
    logic [PC_W-1:0]  pc;
    logic [DAT_W-1:0] status_flag_register;
    logic [2:0]       cycles;
    logic             push;
    logic             pop;
  } bsce_result_t;

endpackage

/* bsce_exec.sv */
// Branch, skip, compare and call/return executor.
// Assumes a decoder drives one instruction per start pulse, on ref_clk_i.
// Summary of operation
// [RQ1] Extended indirect call: PC low from Z, high from high-address reg, 3 cycles.
// [RQ2] Skip-if-equal skips next instruction when registers match; 1/2/3 cycles.
// [RQ3] Skip if register bit is zero; 1/2/3 cycles; flags unchanged.
// [RQ4] Skip if register bit is one; 1/2/3 cycles.
// [RQ5] Skip if I/O register bit is zero; 2/3/4 cycles.
// [RQ6] Skip if I/O register bit is one; 2/3/4 cycles; flags unchanged.
// [RQ7] Branch on selected status flag set or clear; PC+k+1, 2 taken, 1 not.
// [RQ8] Carry branches branch on carry one or zero; 1 or 2 cycles.
// [RQ9] Same-or-higher branches on carry zero, lower on carry one.
// [RQ10] Signed branches test negative XOR overflow, zero or one.
// [RQ11] Half-carry branches on half-carry flag one or zero.
// [RQ12] Transfer-bit branches on T flag one or zero.
// [RQ13] Overflow branches on overflow flag; flags unchanged.
// [RQ14] Interrupt-enable branches on global interrupt flag one or zero.
// [RQ15] Direct data load copies addressed byte to destination; 2 cycles nominal.
// [RQ16] Compares subtract without storing; update Z,C,N,V,S,H in one cycle.
// [RQ17] Call pushes and jumps 3/4 cycles; returns pop 4/5; interrupt exit sets I.
`timescale 1ns/1ps
`default_nettype none
module bsce_exec #(
  parameter int PC_BITS = 22
) (
  // Clock and reset
  input  wire logic                        ref_clk_i,
  input  wire logic                        rstn_i,
  // Instruction issue
  input  wire logic                        start_i,
  input  wire bsce_pkg::bsce_instr_t       instr_i,
  input  wire logic [bsce_pkg::PC_W-1:0]   pc_i,
  input  wire logic [bsce_pkg::DAT_W-1:0]  status_flag_register_i,
  input  wire logic [5:0]                  extended_indirect_high_i,
  input  wire logic [bsce_pkg::PC_W-1:0]   stack_pc_i,
  input  wire logic [bsce_pkg::DAT_W-1:0]  mem_data_i,
  input  wire logic                        mem_wait_i,
  // Results
  output logic                             done_o,
  output bsce_pkg::bsce_result_t           res_o,
  output logic [bsce_pkg::PC_W-1:0]        ret_addr_o,
  output logic                             reg_we_o,
  output logic [bsce_pkg::DAT_W-1:0]       reg_wdata_o,
  output logic                             busy_o
);

  // Elaboration-time refusal of an unsupported width
  if (PC_BITS != bsce_pkg::PC_W) begin : g_pc_bits_chk
    $error("PC_BITS must equal 22");
  end

  // ==========================================================================
  // Combinational execution
  bsce_pkg::bsce_result_t nxt_res;
  logic                   nxt_we;
  logic [7:0]             nxt_wdata;
  logic [bsce_pkg::PC_W-1:0] rel_tgt;
  logic [bsce_pkg::PC_W-1:0] skip_tgt;
  logic [8:0]             diff;
  logic                   cin;
  logic                   take;
  logic [2:0]             skip_cyc;

  always_comb begin
    rel_tgt  = pc_i + {{(bsce_pkg::PC_W-12){instr_i.offset[11]}}, instr_i.offset}
               + 22'h000001;
    skip_tgt = instr_i.next_two_word ? pc_i + 22'h000003 : pc_i + 22'h000002;
    skip_cyc = instr_i.next_two_word ? 3'h3 : 3'h2;
    cin = (instr_i.op == bsce_pkg::OP_CMP_BORROW) ? status_flag_register_i[bsce_pkg::FLG_C] : 1'b0;
    diff = {1'b0, instr_i.opd_a} - {1'b0, instr_i.opd_b} - {8'h00, cin};
    take = 1'b0;
    nxt_we = 1'b0;
    nxt_wdata = 8'h00;
    nxt_res.pc     = pc_i + 22'h000001;
    nxt_res.status_flag_register   = status_flag_register_i;
    nxt_res.cycles = bsce_pkg::CYC_ONE;
    nxt_res.push   = 1'b0;
    nxt_res.pop    = 1'b0;
    case (instr_i.op)
      bsce_pkg::OP_EXTENDED_INDIRECT_CALL: begin
        nxt_res.pc     = {extended_indirect_high_i, instr_i.z_ptr}; // RQ1
        nxt_res.cycles = bsce_pkg::CYC_EXTENDED_INDIRECT_CALL; // RQ1
        nxt_res.push   = 1'b1;
      end
      bsce_pkg::OP_CALL: begin
        nxt_res.pc     = instr_i.target; // RQ17
        nxt_res.push   = 1'b1;
        nxt_res.cycles = instr_i.pc22 ? bsce_pkg::CYC_CALL_LONG : bsce_pkg::CYC_CALL_SHORT;
      end
      bsce_pkg::OP_RET, bsce_pkg::OP_INTERRUPT_EXIT: begin
        nxt_res.pc     = stack_pc_i; // RQ17
        nxt_res.pop    = 1'b1;
        nxt_res.cycles = instr_i.pc22 ? bsce_pkg::CYC_RET_LONG : bsce_pkg::CYC_RET_SHORT;
        if (instr_i.op == bsce_pkg::OP_INTERRUPT_EXIT) begin
          nxt_res.status_flag_register[bsce_pkg::FLG_I] = 1'b1; // RQ17
        end
      end
      bsce_pkg::OP_SKIP_EQ: take = (instr_i.opd_a == instr_i.opd_b); // RQ2
      bsce_pkg::OP_SKIP_RB_CLR: take = ~instr_i.opd_a[instr_i.bit_sel]; // RQ3
      bsce_pkg::OP_SKIP_RB_SET: take = instr_i.opd_a[instr_i.bit_sel]; // RQ4
      bsce_pkg::OP_SKIP_IO_CLR: take = ~instr_i.io_val[instr_i.bit_sel]; // RQ5
      bsce_pkg::OP_SKIP_IO_SET: take = instr_i.io_val[instr_i.bit_sel]; // RQ6
      bsce_pkg::OP_BR_FLAG_SET: take = status_flag_register_i[instr_i.bit_sel]; // RQ7 RQ8 RQ9 RQ11 RQ12 RQ13 RQ14
      bsce_pkg::OP_BR_FLAG_CLR: take = ~status_flag_register_i[instr_i.bit_sel]; // RQ7 RQ8 RQ9 RQ11 RQ12 RQ13 RQ14
      bsce_pkg::OP_BR_SIGNED_GE:
        take = ~(status_flag_register_i[bsce_pkg::FLG_N] ^ status_flag_register_i[bsce_pkg::FLG_V]); // RQ10
      bsce_pkg::OP_BR_SIGNED_LT:
        take = status_flag_register_i[bsce_pkg::FLG_N] ^ status_flag_register_i[bsce_pkg::FLG_V]; // RQ10
      bsce_pkg::OP_CMP, bsce_pkg::OP_CMP_BORROW, bsce_pkg::OP_CMP_IMM: begin
        nxt_res.status_flag_register[bsce_pkg::FLG_C] = diff[8]; // RQ16
        nxt_res.status_flag_register[bsce_pkg::FLG_Z] = (diff[7:0] == 8'h00) &&
          ((instr_i.op != bsce_pkg::OP_CMP_BORROW) || status_flag_register_i[bsce_pkg::FLG_Z]);
        nxt_res.status_flag_register[bsce_pkg::FLG_N] = diff[7];
        nxt_res.status_flag_register[bsce_pkg::FLG_V] = (instr_i.opd_a[7] & ~instr_i.opd_b[7] & ~diff[7])
                                      | (~instr_i.opd_a[7] & instr_i.opd_b[7] & diff[7]);
        nxt_res.status_flag_register[bsce_pkg::FLG_S] = diff[7] ^ nxt_res.status_flag_register[bsce_pkg::FLG_V];
        nxt_res.status_flag_register[bsce_pkg::FLG_H] = (~instr_i.opd_a[3] & instr_i.opd_b[3])
                                      | (instr_i.opd_b[3] & diff[3])
                                      | (diff[3] & ~instr_i.opd_a[3]);
      end
      bsce_pkg::OP_MOVE, bsce_pkg::OP_MOVE_PAIR: begin
        nxt_we    = 1'b1;
        nxt_wdata = instr_i.opd_b;
      end
      bsce_pkg::OP_LOAD_IMM: begin
        nxt_we    = 1'b1;
        nxt_wdata = instr_i.opd_b;
      end
      bsce_pkg::OP_DIRECT_LOAD: begin
        nxt_res.pc     = pc_i + 22'h000002;
        nxt_res.cycles = bsce_pkg::CYC_LDS; // RQ15
        nxt_we         = 1'b1;
        nxt_wdata      = mem_data_i; // RQ15
      end
      default: nxt_res.pc = pc_i + 22'h000001;
    endcase
    case (instr_i.op)
      bsce_pkg::OP_SKIP_EQ, bsce_pkg::OP_SKIP_RB_CLR, bsce_pkg::OP_SKIP_RB_SET: begin
        nxt_res.pc     = take ? skip_tgt : pc_i + 22'h000001;
        nxt_res.cycles = take ? skip_cyc : bsce_pkg::CYC_ONE;
      end
      bsce_pkg::OP_SKIP_IO_CLR, bsce_pkg::OP_SKIP_IO_SET: begin
        nxt_res.pc     = take ? skip_tgt : pc_i + 22'h000001;
        nxt_res.cycles = (take ? skip_cyc : bsce_pkg::CYC_ONE) + bsce_pkg::CYC_IO_EXTRA;
      end
      bsce_pkg::OP_BR_FLAG_SET, bsce_pkg::OP_BR_FLAG_CLR,
      bsce_pkg::OP_BR_SIGNED_GE, bsce_pkg::OP_BR_SIGNED_LT: begin
        nxt_res.pc     = take ? rel_tgt : pc_i + 22'h000001;
        nxt_res.cycles = take ? bsce_pkg::CYC_TWO : bsce_pkg::CYC_ONE;
      end
      default: nxt_res.cycles = nxt_res.cycles;
    endcase
  end

  // ==========================================================================
  // Cycle counter: done pulses after the counted cycles
  logic [2:0] cnt_ff;
  logic       wait_ff;
  bsce_pkg::bsce_result_t res_hold_ff;
  logic       we_hold_ff;
  logic [7:0] wdata_hold_ff;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff        <= 3'h0;
      wait_ff       <= 1'b0;
      res_hold_ff   <= '0;
      we_hold_ff    <= 1'b0;
      wdata_hold_ff <= 8'h00;
    end else if (start_i && cnt_ff == 3'h0) begin
      cnt_ff        <= nxt_res.cycles;
      wait_ff       <= instr_i.op == bsce_pkg::OP_DIRECT_LOAD;
      res_hold_ff   <= nxt_res;
      we_hold_ff    <= nxt_we;
      wdata_hold_ff <= nxt_wdata;
    end else if (cnt_ff != 3'h0) begin
      if (!(wait_ff && mem_wait_i && cnt_ff == 3'h1)) begin
        cnt_ff <= cnt_ff - 3'h1; // RQ15
      end
      if (wait_ff && !mem_wait_i) begin
        wdata_hold_ff <= mem_data_i;
      end
    end
  end

  // ==========================================================================
  // Registered outputs
  logic finish;
  assign finish = (cnt_ff == 3'h1) && !(wait_ff && mem_wait_i);

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_o      <= 1'b0;
      res_o       <= '0;
      ret_addr_o  <= bsce_pkg::PC_RST;
      reg_we_o    <= 1'b0;
      reg_wdata_o <= 8'h00;
      busy_o      <= 1'b0;
    end else begin
      done_o   <= finish;
      reg_we_o <= finish && we_hold_ff;
      busy_o   <= (start_i && cnt_ff == 3'h0) || (cnt_ff > 3'h1) || (cnt_ff != 3'h0 && !finish);
      if (finish) begin
        res_o       <= res_hold_ff;
        reg_wdata_o <= wdata_hold_ff;
      end
      if (start_i && cnt_ff == 3'h0) begin
        ret_addr_o <= pc_i + (instr_i.op == bsce_pkg::OP_CALL ? 22'h000002 : 22'h000001);
      end
    end
  end

  // ==========================================================================
  // Checks
  a_done_after_start: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    start_i && cnt_ff == 3'h0 && instr_i.op == bsce_pkg::OP_EXTENDED_INDIRECT_CALL
    |-> ##4 done_o && res_o.pc[15:0] == $past(instr_i.z_ptr, 4)) // RQ1
    else $error("extended_indirect_call timing or target wrong");
  a_branch_taken_pc: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    start_i && cnt_ff == 3'h0 && instr_i.op == bsce_pkg::OP_BR_FLAG_SET
    && status_flag_register_i[instr_i.bit_sel] |-> ##3 done_o && res_o.pc == $past(rel_tgt, 3)) // RQ7
    else $error("taken branch wrong");
  a_branch_not_taken: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    start_i && cnt_ff == 3'h0 && instr_i.op == bsce_pkg::OP_BR_FLAG_CLR
    && status_flag_register_i[instr_i.bit_sel] |-> ##2 done_o && res_o.pc == $past(pc_i, 2) + 22'h000001) // RQ7
    else $error("untaken branch wrong");
  a_signed_ge_cond: assert property (@(posedge ref_clk_i)
    instr_i.op == bsce_pkg::OP_BR_SIGNED_GE |-> take == (status_flag_register_i[2] == status_flag_register_i[3])) // RQ10
    else $error("signed ge condition wrong");
  a_skip_io_cycles: assert property (@(posedge ref_clk_i)
    instr_i.op == bsce_pkg::OP_SKIP_IO_SET && !take |-> nxt_res.cycles == 3'h2) // RQ6
    else $error("io skip cycles wrong");
  a_skip_reg_pc: assert property (@(posedge ref_clk_i)
    instr_i.op == bsce_pkg::OP_SKIP_RB_CLR && !instr_i.opd_a[instr_i.bit_sel]
    |-> nxt_res.pc == skip_tgt && nxt_res.status_flag_register == status_flag_register_i) // RQ3
    else $error("register bit skip wrong");
  a_compare_zero: assert property (@(posedge ref_clk_i)
    instr_i.op == bsce_pkg::OP_CMP && instr_i.opd_a == instr_i.opd_b
    |-> nxt_res.status_flag_register[1] && !nxt_res.status_flag_register[0] && !nxt_we) // RQ16
    else $error("compare flags wrong");
  a_interrupt_exit_sets_i: assert property (@(posedge ref_clk_i)
    instr_i.op == bsce_pkg::OP_INTERRUPT_EXIT |-> nxt_res.status_flag_register[7] && nxt_res.pop) // RQ17
    else $error("interrupt exit flag wrong");

endmodule
`default_nettype wire

/* branch_skip_compare_exec_test.sv */
// Self-checking bench for the branch, skip, compare and call/return executor.
// Assumes bsce_pkg and bsce_exec are compiled first; one clock, active-low reset.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (a), (b)); end end
module branch_skip_compare_exec_test;
  localparam logic [21:0] PC0 = 22'h012340;
  logic                  ref_clk_i;
  logic                  rstn_i;
  logic                  start_i;
  bsce_pkg::bsce_instr_t instr_i;
  logic [7:0]            status_flag_register_i;
  logic                  done_o;
  bsce_pkg::bsce_result_t res_o;
  logic [21:0]           ret_addr_o;
  logic                  reg_we_o;
  logic [7:0]            reg_wdata_o;
  logic                  busy_o;
  logic                  mem_wait_i;
  logic                  busy_g;
  int                    n_mismatch;
  int                    checks_done;
  int                    lat_g;

  bsce_exec uut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .start_i(start_i), .instr_i(instr_i),
    .pc_i(PC0), .status_flag_register_i(status_flag_register_i), .extended_indirect_high_i(6'h2A), .stack_pc_i(22'h2ABCDE),
    .mem_data_i(8'hC3), .mem_wait_i(mem_wait_i), .done_o(done_o), .res_o(res_o),
    .ret_addr_o(ret_addr_o), .reg_we_o(reg_we_o), .reg_wdata_o(reg_wdata_o), .busy_o(busy_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================================================
  // Helpers
  function automatic bsce_pkg::bsce_instr_t mk(input bsce_pkg::bsce_op_t op);
    bsce_pkg::bsce_instr_t i;
    i = '0;
    i.op = op;
    return i;
  endfunction

  // Subtract-and-flag reference; chain keeps Z only if it was set
  function automatic logic [7:0] cmp_flags(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic [7:0] sr,
                                           input logic chain);
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] f;
    logic       v;
    d = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
    v = (a[7] ^ b[7]) & (a[7] ^ d[7]);
    f = sr;
    f[0] = d[8];
    f[1] = (d[7:0] == 8'h00) & (~chain | sr[1]);
    f[2] = d[7];
    f[3] = v;
    f[4] = d[7] ^ v;
    f[5] = h[4];
    return f;
  endfunction

  task automatic issue(input bsce_pkg::bsce_instr_t ins, input logic [7:0] sr);
    lat_g = 0;
    @(posedge ref_clk_i);
    start_i <= 1'b1;
    instr_i <= ins;
    status_flag_register_i  <= sr;
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    #1;
    busy_g = busy_o;
    while (lat_g < 12) begin
      @(posedge ref_clk_i);
      lat_g++;
      #1;
      if (done_o === 1'b1) break;
    end
  endtask

  task automatic chk_res(input logic [21:0] pc, input int cyc, input logic [7:0] sr);
    `CHK(lat_g, cyc)
    `CHK(res_o.cycles, 3'(cyc))
    `CHK(res_o.pc, pc)
    `CHK(res_o.status_flag_register, sr)
    `CHK(busy_g, 1'b1)
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_extended_indirect_call;
    bsce_pkg::bsce_instr_t ins;
    ins = mk(bsce_pkg::OP_EXTENDED_INDIRECT_CALL);
    ins.z_ptr = 16'hBEEF;
    issue(ins, 8'h5A);
    chk_res({6'h2A, 16'hBEEF}, 3, 8'h5A);
    `CHK(res_o.push, 1'b1)
    `CHK(ret_addr_o, PC0 + 22'h1)
  endtask

  task automatic t_skips;
    bsce_pkg::bsce_op_t ops [5] = '{bsce_pkg::OP_SKIP_EQ, bsce_pkg::OP_SKIP_RB_CLR,
      bsce_pkg::OP_SKIP_RB_SET, bsce_pkg::OP_SKIP_IO_CLR, bsce_pkg::OP_SKIP_IO_SET};
    bsce_pkg::bsce_instr_t ins;
    logic [7:0] v;
    int base;
    for (int o = 0; o < 5; o++) begin
      for (int c = 0; c < 2; c++) begin
        for (int w = 0; w < 2; w++) begin
          v = (((o == 1) || (o == 3)) ^ c[0]) ? 8'h20 : 8'hDF;
          ins = mk(ops[o]);
          ins.bit_sel = 3'h5;
          ins.next_two_word = w[0];
          ins.opd_a = v;
          ins.opd_b = ((o != 0) || c[0]) ? v : ~v;
          ins.io_val = v;
          base = (o >= 3) ? 2 : 1;
          issue(ins, 8'h3C);
          chk_res(c[0] ? PC0 + 22'(2 + w) : PC0 + 22'h1, c[0] ? base + 1 + w : base, 8'h3C);
        end
      end
    end
  endtask

  task automatic t_flag_branches;
    bsce_pkg::bsce_instr_t ins;
    logic [7:0] sr;
    logic tk;
    for (int s = 0; s < 8; s++) begin
      for (int st = 0; st < 2; st++) begin
        for (int f = 0; f < 2; f++) begin
          ins = mk(st[0] ? bsce_pkg::OP_BR_FLAG_SET : bsce_pkg::OP_BR_FLAG_CLR);
          ins.bit_sel = 3'(s);
          ins.offset = s[0] ? 12'hFFD : 12'h7FF;
          sr = f[0] ? (8'h01 << s) : ~(8'h01 << s);
          tk = (st[0] == f[0]);
          issue(ins, sr);
          chk_res(tk ? (s[0] ? PC0 - 22'h2 : PC0 + 22'h800) : PC0 + 22'h1, tk ? 2 : 1, sr);
        end
      end
    end
  endtask

  task automatic t_signed;
    bsce_pkg::bsce_instr_t ins;
    logic [7:0] sr;
    logic tk;
    for (int k = 0; k < 8; k++) begin
      ins = mk(k[2] ? bsce_pkg::OP_BR_SIGNED_LT : bsce_pkg::OP_BR_SIGNED_GE);
      ins.offset = 12'h010;
      // Sign flag set against N xor V on purpose
      sr = {3'h0, ~(k[0] ^ k[1]), k[1], k[0], 2'h0};
      tk = (k[0] ^ k[1]) == k[2];
      issue(ins, sr);
      chk_res(tk ? PC0 + 22'h11 : PC0 + 22'h1, tk ? 2 : 1, sr);
    end
  endtask

  task automatic t_compare;
    logic [7:0] as [4] = '{8'h00, 8'h80, 8'h3A, 8'h10};
    logic [7:0] bs [4] = '{8'h00, 8'h01, 8'h3A, 8'h28};
    bsce_pkg::bsce_instr_t ins;
    logic [7:0] sr;
    for (int o = 0; o < 3; o++) begin
      for (int p = 0; p < 8; p++) begin
        ins = mk(bsce_pkg::bsce_op_t'(5'h06 + 5'(o)));
        ins.opd_a = as[p % 4];
        ins.opd_b = bs[p % 4];
        sr = (p >= 4) ? 8'hC3 : 8'hC1;
        issue(ins, sr);
        chk_res(PC0 + 22'h1, 1, cmp_flags(as[p % 4], bs[p % 4], (o == 1), sr, (o == 1)));
      end
    end
  endtask

  task automatic t_call_ret;
    bsce_pkg::bsce_instr_t ins;
    for (int l = 0; l < 2; l++) begin
      ins = mk(bsce_pkg::OP_CALL);
      ins.target = 22'h2F0F0F;
      ins.pc22 = l[0];
      issue(ins, 8'h05);
      chk_res(22'h2F0F0F, 3 + l, 8'h05);
      `CHK(res_o.push, 1'b1)
      `CHK(ret_addr_o, PC0 + 22'h2)
      for (int r = 0; r < 2; r++) begin
        ins = mk(r[0] ? bsce_pkg::OP_INTERRUPT_EXIT : bsce_pkg::OP_RET);
        ins.pc22 = l[0];
        issue(ins, 8'h05);
        chk_res(22'h2ABCDE, 4 + l, r[0] ? 8'h85 : 8'h05);
        `CHK(res_o.pop, 1'b1)
      end
    end
  endtask

  task automatic t_load;
    issue(mk(bsce_pkg::OP_DIRECT_LOAD), 8'h2B);
    `CHK(lat_g, 2)
    `CHK(reg_we_o, 1'b1)
    `CHK(reg_wdata_o, 8'hC3)
    `CHK(res_o.status_flag_register, 8'h2B)
    mem_wait_i <= 1'b1;
    fork
      issue(mk(bsce_pkg::OP_DIRECT_LOAD), 8'h2B);
      begin
        repeat (5) @(posedge ref_clk_i);
        mem_wait_i <= 1'b0;
      end
    join
    `CHK(lat_g, 4)
    `CHK(reg_we_o, 1'b1)
    `CHK(reg_wdata_o, 8'hC3)
  endtask

  // Register copies and immediate load write opd_b in one cycle
  task automatic t_moves;
    bsce_pkg::bsce_instr_t ins;
    for (int m = 0; m < 3; m++) begin
      ins = mk(bsce_pkg::bsce_op_t'(5'h11 + 5'(m)));
      ins.opd_b = 8'h96 ^ 8'(m);
      issue(ins, 8'h41);
      chk_res(PC0 + 22'h1, 1, 8'h41);
      `CHK(reg_we_o, 1'b1)
      `CHK(reg_wdata_o, 8'h96 ^ 8'(m))
    end
  endtask

  // ==========================================================================
  // Verdict and main sequence
  task automatic end_sim;
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(25 * 8000);
    n_mismatch++;
    end_sim();
  end

  initial begin
    n_mismatch = 0;
    checks_done = 0;
    rstn_i = 1'b0;
    start_i = 1'b0;
    instr_i = '0;
    status_flag_register_i = 8'h00;
    mem_wait_i = 1'b0;
    busy_g = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_extended_indirect_call();
    t_skips();
    t_flag_branches();
    t_signed();
    t_compare();
    t_call_ret();
    t_load();
    t_moves();
    end_sim();
  end
endmodule
`default_nettype wire
